// ---- tick_wdog.sv ----
// Periodic tick and watchdog with Avalon-MM register slave
`timescale 1ns/100ps
module tick_wdog
   import tick_wdog_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // Module clock and mode inputs
   input  wire logic       slow_clk_en_i,
   input  wire logic       special_mode_i,
   input  wire logic       wait_mode_i,
   input  wire logic       debug_mode_i,
   input  wire logic       pll_supply_input_i,
   input  wire logic       clk_fail_i,
   // Avalon-MM slave
   input  wire logic [7:0] avs_address_i,
   input  wire logic       avs_read_i,
   input  wire logic       avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0] avs_byteenable_i,
   output logic [31:0]     avs_readdata_o,
   output logic            avs_waitrequest_o,
   // Outputs
   output logic            tick_irq_o,
   output logic            wdog_reset_o,
   output logic            clkmon_reset_o,
   output logic            clkmon_active_o
);
   // ------------------------------------------------------------------
   // Reset release and input synchronisers
   // ------------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic       rst_n;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) rst_sync_ff <= 2'h0;
      else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   localparam int NSYNC = 6;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_ff;
   logic [NSYNC-1:0] s2_ff;
   logic [NSYNC-1:0] s3_ff;
   logic [NSYNC-1:0] filt_ff;
   assign raw_in = {slow_clk_en_i, special_mode_i, wait_mode_i, debug_mode_i,
                    pll_supply_input_i, clk_fail_i};
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff   <= '0;
         s2_ff   <= '0;
         s3_ff   <= '0;
         filt_ff <= '0;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < NSYNC; i++) begin
            if (s2_ff[i] == s3_ff[i]) filt_ff[i] <= s3_ff[i];
         end
      end
   end
   logic slow_en;
   logic special;
   logic in_wait;
   logic in_debug;
   logic pll_sup;
   logic clk_fail;
   assign slow_en  = filt_ff[5];
   assign special  = filt_ff[4];
   assign in_wait  = filt_ff[3];
   assign in_debug = filt_ff[2];
   assign pll_sup  = filt_ff[1];
   assign clk_fail = filt_ff[0];

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic       tick_irq_en_ff;
   logic       stop_in_wait_ff;
   logic       stop_in_debug_ff;
   logic       tick_divider_bypass_ff;
   logic [2:0] tick_rate_select_ff;
   logic       tick_flag_ff;
   logic       clkmon_enable_ff;
   logic       clkmon_force_enable_ff;
   logic       force_failure_reset_ff;
   logic       window_mode_ff;
   logic       reset_disable_ff;
   logic [2:0] watchdog_rate_select_ff;
   logic       once_ctrl_ff;
   logic       once_wdog_ff;
   logic       strap_done_ff;
   logic [2:0] strap_cnt_ff;

   logic       wr_acc;
   logic       rd_acc;
   logic       lane0;
   logic [7:0] wd;
   logic       wr_tctl;
   logic       wr_tflg;
   logic       wr_wctl;
   logic       wr_serv;
   logic       rd_done_ff;
   assign lane0   = avs_byteenable_i[0];
   assign wd      = avs_writedata_i[7:0];
   assign wr_acc  = avs_write_i & lane0;
   assign rd_acc  = avs_read_i & ~rd_done_ff;
   assign wr_tctl = wr_acc && avs_address_i == IDX_TICK_CTRL;
   assign wr_tflg = wr_acc && avs_address_i == IDX_TICK_FLAG;
   assign wr_wctl = wr_acc && avs_address_i == IDX_WDOG_CTRL;
   assign wr_serv = wr_acc && avs_address_i == IDX_WDOG_SERV;
   // One wait state on reads so read data stand as waitrequest drops
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) rd_done_ff <= 1'b0;
      else rd_done_ff <= avs_read_i & ~rd_done_ff;
   end
   assign avs_waitrequest_o = avs_read_i & ~rd_done_ff;

   logic halted;
   logic prescale_tick;
   logic tick_period;
   logic wdog_run;

   // Tick control register
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         tick_irq_en_ff         <= 1'b0;
         stop_in_wait_ff        <= 1'b0;
         stop_in_debug_ff       <= 1'b0;
         tick_divider_bypass_ff <= 1'b0;
         tick_rate_select_ff    <= 3'h0;
         once_ctrl_ff           <= 1'b0;
      end else if (wr_tctl) begin
         tick_irq_en_ff      <= wd[TC_IRQ_EN];
         tick_rate_select_ff <= wd[2:0];
         if (special || !once_ctrl_ff) begin
            stop_in_wait_ff  <= wd[TC_SWAI];
            stop_in_debug_ff <= wd[TC_SBCK];
         end
         if (special) tick_divider_bypass_ff <= wd[TC_BYP];
         once_ctrl_ff <= 1'b1;
      end
   end

   // Tick flag, set wins over clear
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) tick_flag_ff <= 1'b0;
      else if (tick_period) tick_flag_ff <= 1'b1;
      else if (wr_tflg && wd[TF_FLAG]) tick_flag_ff <= 1'b0;
   end
   assign tick_irq_o = tick_flag_ff & tick_irq_en_ff;

   // Strap sampling waits for the input filters to fill
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) strap_cnt_ff <= 3'h0;
      else if (strap_cnt_ff != STRAP_WAIT) strap_cnt_ff <= strap_cnt_ff + 3'h1;
   end

   // Watchdog control register
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         clkmon_enable_ff        <= 1'b0;
         clkmon_force_enable_ff  <= 1'b0;
         force_failure_reset_ff  <= 1'b0;
         window_mode_ff          <= 1'b0;
         reset_disable_ff        <= 1'b0;
         watchdog_rate_select_ff <= WDOG_RATE_RST;
         once_wdog_ff            <= 1'b0;
         strap_done_ff           <= 1'b0;
      end else if (!strap_done_ff) begin
         if (strap_cnt_ff == STRAP_WAIT) begin
            strap_done_ff    <= 1'b1;
            clkmon_enable_ff <= pll_sup;
            reset_disable_ff <= special;
         end
      end else if (wr_wctl) begin
         clkmon_enable_ff <= wd[WC_CME];
         if (special || !once_wdog_ff) begin
            if (special || wd[WC_CLKMON_FORCE_ENABLE]) clkmon_force_enable_ff <= wd[WC_CLKMON_FORCE_ENABLE];
            window_mode_ff          <= wd[WC_WIN];
            watchdog_rate_select_ff <= wd[2:0];
         end
         if (special) begin
            force_failure_reset_ff <= wd[WC_FORCE];
            reset_disable_ff       <= wd[WC_RESET_DISABLE];
         end
         once_wdog_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Shared prescale chain
   // ------------------------------------------------------------------
   logic [PRESCALE_W-1:0] pre_ff;
   logic [CHAIN_W-1:0]    wdog_cnt_ff;
   logic [CHAIN_W-1:0]    tick_cnt_ff;
   assign halted = (stop_in_wait_ff & in_wait) | (stop_in_debug_ff & in_debug);
   assign prescale_tick = slow_en && !halted && pre_ff == '1;

   // Initial prescaler never cleared by a restart
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) pre_ff <= '0;
      else if (slow_en && !halted) pre_ff <= pre_ff + 1'b1;
   end

   function automatic logic [CHAIN_W-1:0] tick_limit(input logic [2:0] code, input logic byp);
      logic [CHAIN_W-1:0] v;
      v = '0;
      if (byp) v = CHAIN_W'(1) << (BYPASS_DIV_LOG - PRESCALE_W);
      else v = CHAIN_W'(1) << (TICK_BASE_LOG + code - PRESCALE_W);
      return v;
   endfunction

   function automatic logic [CHAIN_W-1:0] wdog_limit(input logic [2:0] code);
      logic [4:0] e;
      e = 5'd0;
      case (code)
         3'h1: e = 5'd13;
         3'h2: e = 5'd15;
         3'h3: e = 5'd17;
         3'h4: e = 5'd19;
         3'h5: e = 5'd21;
         3'h6: e = 5'd22;
         3'h7: e = 5'd23;
         default: e = 5'd13;
      endcase
      return CHAIN_W'(1) << (e - 5'(PRESCALE_W));
   endfunction

   // Tick counter; bypass gives one tick per prescaler wrap
   logic tick_step;
   assign tick_step = prescale_tick;
   assign tick_period = tick_rate_select_ff != 3'h0 && tick_step &&
                        tick_cnt_ff >= tick_limit(tick_rate_select_ff, tick_divider_bypass_ff) - 1'b1;
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) tick_cnt_ff <= '0;
      else if (tick_rate_select_ff == 3'h0) tick_cnt_ff <= '0;
      else if (tick_period) tick_cnt_ff <= '0;
      else if (tick_step) tick_cnt_ff <= tick_cnt_ff + 1'b1;
   end

   // ------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------
   logic armed_ff;
   logic wdog_expire;
   logic early;
   logic bad_serv;
   logic [CHAIN_W-1:0] lim;
   assign wdog_run = watchdog_rate_select_ff != 3'h0;
   assign lim = wdog_limit(watchdog_rate_select_ff);
   assign wdog_expire = wdog_run && prescale_tick && wdog_cnt_ff >= lim - 1'b1;
   assign early = window_mode_ff && wdog_cnt_ff < lim - (lim >> 2);
   assign bad_serv = wr_serv && wdog_run &&
                     ((wd != SERV_ARM && wd != SERV_RESTART) || early);

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         wdog_cnt_ff <= '0;
         armed_ff    <= 1'b0;
      end else if (!wdog_run) begin
         wdog_cnt_ff <= '0;
         armed_ff    <= 1'b0;
      end else if (wr_serv && wd == SERV_RESTART && armed_ff) begin
         wdog_cnt_ff <= '0;
         armed_ff    <= 1'b0;
      end else begin
         if (wr_serv && wd == SERV_ARM) armed_ff <= 1'b1;
         if (prescale_tick) wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
      end
   end

   // Reset requests, sticky until system reset
   logic cm_active;
   assign cm_active = clkmon_force_enable_ff | clkmon_enable_ff;
   assign clkmon_active_o = cm_active;
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         wdog_reset_o   <= 1'b0;
         clkmon_reset_o <= 1'b0;
      end else if (!reset_disable_ff) begin
         if (wdog_expire || bad_serv || (force_failure_reset_ff && wdog_run))
            wdog_reset_o <= 1'b1;
         if (cm_active && (clk_fail || force_failure_reset_ff))
            clkmon_reset_o <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) avs_readdata_o <= 32'h0;
      else if (rd_acc) begin
         case (avs_address_i)
            IDX_TICK_CTRL: avs_readdata_o <= {24'h0, tick_irq_en_ff, stop_in_wait_ff, stop_in_debug_ff,
                                              1'b0, tick_divider_bypass_ff, tick_rate_select_ff};
            IDX_TICK_FLAG: avs_readdata_o <= {24'h0, tick_flag_ff, 7'h0};
            IDX_WDOG_CTRL: avs_readdata_o <= {24'h0, clkmon_enable_ff, clkmon_force_enable_ff,
                                              force_failure_reset_ff, window_mode_ff, reset_disable_ff,
                                              watchdog_rate_select_ff};
            default: avs_readdata_o <= 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tick_irq_o == (tick_flag_ff && tick_irq_en_ff)) else $error("tick irq mismatch");
   chk_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tick_period |=> tick_flag_ff) else $error("tick flag not set");
   chk_bad_code: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_serv && wdog_run && !reset_disable_ff && wd != SERV_ARM && wd != SERV_RESTART) |=> wdog_reset_o)
      else $error("bad service not reset");
   chk_reset_disable_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (reset_disable_ff && !wdog_reset_o) |=> !wdog_reset_o) else $error("reset despite disable");
   chk_byp_normal: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!special && strap_done_ff) |=> $stable(tick_divider_bypass_ff)) else $error("bypass changed");
   chk_expire_rst: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wdog_expire && !reset_disable_ff) |=> wdog_reset_o) else $error("expiry no reset");
   chk_rate_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      tick_rate_select_ff == 3'h0 |-> !tick_period) else $error("tick while off");
   chk_force_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (clkmon_force_enable_ff && !special) |=> clkmon_active_o) else $error("monitor dropped");
   chk_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_tflg && wd[TF_FLAG] && !tick_period) |=> !tick_flag_ff)
      else $error("tick flag not cleared");
   chk_flag_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_tflg && !wd[TF_FLAG] && tick_flag_ff) |=> tick_flag_ff)
      else $error("tick flag lost on zero write");
   chk_flag_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!tick_flag_ff && !tick_period) |=> !tick_flag_ff)
      else $error("tick flag set without period");
   chk_bypass_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (tick_divider_bypass_ff && tick_rate_select_ff != 3'h0 && prescale_tick) |-> tick_period)
      else $error("bypass step without tick");
   chk_halt_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (stop_in_wait_ff && in_wait) |-> !prescale_tick)
      else $error("counters run in wait");
   chk_serv_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (rd_acc && avs_address_i == IDX_WDOG_SERV) |=> avs_readdata_o == 32'h0)
      else $error("service register read nonzero");
   chk_window_early: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_serv && wdog_run && early && !reset_disable_ff) |=> wdog_reset_o)
      else $error("early service not reset");
   chk_arm_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_serv && wdog_run && wd == SERV_ARM) |=> armed_ff)
      else $error("arm value not taken");
   chk_restart_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_serv && wdog_run && wd == SERV_RESTART && armed_ff) |=> (wdog_cnt_ff == '0 && !armed_ff))
      else $error("restart did not clear count");
   chk_wdog_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !wdog_run |=> wdog_cnt_ff == '0)
      else $error("watchdog count while off");
   chk_force_wdog: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (force_failure_reset_ff && wdog_run && !reset_disable_ff) |=> wdog_reset_o)
      else $error("forced watchdog reset missing");
   chk_force_clkmon: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (force_failure_reset_ff && cm_active && !reset_disable_ff) |=> clkmon_reset_o)
      else $error("forced monitor reset missing");
   chk_clkmon_fail: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (cm_active && clk_fail && !reset_disable_ff) |=> clkmon_reset_o)
      else $error("clock failure not reset");
   chk_reset_disable_clkmon: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (reset_disable_ff && !clkmon_reset_o) |=> !clkmon_reset_o)
      else $error("monitor reset despite disable");
   chk_once_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_wctl && strap_done_ff && once_wdog_ff && !special) |=> $stable(watchdog_rate_select_ff))
      else $error("rate written twice");
   chk_strap_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!strap_done_ff && strap_cnt_ff == STRAP_WAIT) |=> clkmon_enable_ff == $past(pll_sup))
      else $error("monitor enable strap wrong");
endmodule

// ---- tick_wdog_pkg.sv ----
// Constants for the periodic tick and watchdog block
//
// Summary of operation
// - Bypass set feeds tick logic with module clock divided by 4.
// - Bypass writes ignored in normal modes, accepted in special modes.
// - Tick rate zero stops tick; code n gives period 2^(12+n).
// - Tick flag bit 7 sets each elapsed period, clear until first.
// - Writing one to flag bit 7 clears it; zero leaves it.
// - Monitor enabled and force clear: clock failure triggers monitor reset.
// - Monitor enable loads from the PLL supply input at reset.
// - Force-monitor set in normal modes keeps monitoring active until reset.
// - Force-monitor, window and rate bits write once in normal modes.
// - Force-failure bit forces monitor and/or watchdog reset as enabled.
// - Reset-disable blocks all system resets; special-only write, mode reset.
// - Watchdog rate zero off; codes 1-7 select 2^13..2^23 time-outs.
// - In window mode a service write before last quarter resets.
// - Arm value repeatable in window; restart value restarts time-out.
// - Restart does not clear the shared initial prescale divider.
// - Service is arm value then restart value; restart after second.
// - Expiry before completed service sequence asserts watchdog reset.
// - Other service values reset immediately; service register reads zero.
// - Tick interrupt requested while flag set and enable one.
// - Stop-in-wait halts tick and watchdog counters in wait mode.
package tick_wdog_pkg;
   // ------------------------------------------------------------------
   // Register map (byte addresses = index * 4)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_TICK_CTRL = 8'h14;
   localparam logic [7:0] IDX_TICK_FLAG = 8'h15;
   localparam logic [7:0] IDX_WDOG_CTRL = 8'h16;
   localparam logic [7:0] IDX_WDOG_SERV = 8'h17;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int TC_IRQ_EN  = 7;
   localparam int TC_SWAI    = 6;
   localparam int TC_SBCK    = 5;
   localparam int TC_BYP     = 3;
   localparam int TF_FLAG    = 7;
   localparam int WC_CME     = 7;
   localparam int WC_CLKMON_FORCE_ENABLE    = 6;
   localparam int WC_FORCE   = 5;
   localparam int WC_WIN     = 4;
   localparam int WC_RESET_DISABLE    = 3;
   // ------------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------------
   localparam logic [2:0] WDOG_RATE_RST = 3'h7;
   localparam logic [7:0] SERV_ARM      = 8'h55;
   localparam logic [7:0] SERV_RESTART  = 8'hAA;
   localparam int         CHAIN_W       = 24;
   localparam int         PRESCALE_W    = 2;
   localparam int         BYPASS_DIV_LOG = 2;
   localparam int         TICK_BASE_LOG = 12;
   localparam logic [2:0] STRAP_WAIT    = 3'h4;
endpackage

// ---- tick_wdog_tb_top.sv ----
// Self-checking testbench for the periodic tick and watchdog block
`timescale 1ns/100ps
module tick_wdog_tb_top;
   import tick_wdog_pkg::*;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic        clk_sys_i;
   logic        rst_n_i;
   logic        slow_clk_en_i;
   logic        special_mode_i;
   logic        wait_mode_i;
   logic        debug_mode_i;
   logic        pll_supply_input_i;
   logic        clk_fail_i;
   logic [7:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        tick_irq_o;
   logic        wdog_reset_o;
   logic        clkmon_reset_o;
   logic        clkmon_active_o;
   int          errors;
   int          checks;
   logic [7:0]  rdat;
   tick_wdog u_tick_wdog (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_clk_en_i(slow_clk_en_i),
      .special_mode_i(special_mode_i), .wait_mode_i(wait_mode_i), .debug_mode_i(debug_mode_i),
      .pll_supply_input_i(pll_supply_input_i), .clk_fail_i(clk_fail_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .tick_irq_o(tick_irq_o), .wdog_reset_o(wdog_reset_o),
      .clkmon_reset_o(clkmon_reset_o), .clkmon_active_o(clkmon_active_o));
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // ------------------------------------------------------------------
   // Bus, wait and compare tasks
   // ------------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int i;
      @(posedge clk_sys_i);
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      avs_address_i   <= idx;
      avs_writedata_i <= {24'h000000, d};
      for (i = 0; i < 100; i++) begin
         @(posedge clk_sys_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      rdat = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      if (i == 100) begin
         errors++;
         $display("wrong value at %0t: bus hang", $time);
         conclude();
      end
   endtask
   task automatic cmp8(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      checks++;
      if (rdat !== exp) begin
         errors++;
         $display("wrong value at %0t: index %0h read %0h expected %0h", $time, idx, rdat, exp);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = tick_irq_o;
         1: pick = wdog_reset_o;
         2: pick = clkmon_reset_o;
         default: pick = clkmon_active_o;
      endcase
   endfunction
   task automatic wait_hi(input int s, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(posedge clk_sys_i);
         #1;
         if (pick(s) === 1'b1) break;
      end
      checks++;
      if (i == n) begin
         errors++;
         $display("wrong value at %0t: output %0d never rose", $time, s);
         conclude();
      end
   endtask
   task automatic hold_lo(input int s, input int n, input logic v);
      int i;
      checks++;
      for (i = 0; i < n; i++) begin
         @(posedge clk_sys_i);
         #1;
         if (pick(s) !== v) begin
            errors++;
            $display("wrong value at %0t: output %0d left level %0b", $time, s, v);
            break;
         end
      end
   endtask
   task automatic do_reset(input logic spec, input logic pll);
      @(posedge clk_sys_i);
      rst_n_i            <= 1'b0;
      special_mode_i     <= spec;
      pll_supply_input_i <= pll;
      clk_fail_i         <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
   endtask
   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      errors = 0; checks = 0; rst_n_i = 1'b0; slow_clk_en_i = 1'b1; special_mode_i = 1'b0;
      wait_mode_i = 1'b0; debug_mode_i = 1'b0; pll_supply_input_i = 1'b1; clk_fail_i = 1'b0;
      avs_address_i = 8'h00; avs_read_i = 1'b0; avs_write_i = 1'b0;
      avs_writedata_i = 32'h00000000; avs_byteenable_i = 4'hF;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      // Normal mode, supply high: resets, tick period, flag clear, service
      cmp8(IDX_WDOG_CTRL, 8'h87);
      cmp8(IDX_TICK_FLAG, 8'h00);
      hold_lo(3, 1, 1'b1);
      bus(1'b1, IDX_TICK_CTRL, 8'h89);
      cmp8(IDX_TICK_CTRL, 8'h81);
      hold_lo(0, 7000, 1'b0);
      wait_hi(0, 2000);
      cmp8(IDX_TICK_FLAG, 8'h80);
      bus(1'b1, IDX_TICK_FLAG, 8'h00);
      hold_lo(0, 2, 1'b1);
      bus(1'b1, IDX_TICK_FLAG, 8'h80);
      hold_lo(0, 7900, 1'b0);
      wait_hi(0, 600);
      bus(1'b1, IDX_WDOG_SERV, SERV_ARM);
      bus(1'b1, IDX_WDOG_SERV, SERV_RESTART);
      bus(1'b1, IDX_WDOG_CTRL, 8'h0F);
      bus(1'b1, IDX_WDOG_CTRL, 8'h87);
      cmp8(IDX_WDOG_CTRL, 8'h87);
      bus(1'b1, IDX_WDOG_CTRL, 8'h01);
      cmp8(IDX_WDOG_CTRL, 8'h07);
      cmp8(IDX_WDOG_SERV, 8'h00);
      $display("test reset_tick_service done");
      // Normal mode, supply low: forced monitor, monitor reset, expiry
      do_reset(1'b0, 1'b0);
      cmp8(IDX_WDOG_CTRL, 8'h07);
      hold_lo(3, 1, 1'b0);
      bus(1'b1, IDX_WDOG_CTRL, 8'h41);
      bus(1'b1, IDX_WDOG_CTRL, 8'h01);
      cmp8(IDX_WDOG_CTRL, 8'h41);
      hold_lo(3, 1, 1'b1);
      hold_lo(2, 10, 1'b0);
      @(posedge clk_sys_i);
      clk_fail_i <= 1'b1;
      wait_hi(2, 20);
      @(posedge clk_sys_i);
      clk_fail_i <= 1'b0;
      hold_lo(1, 7500, 1'b0);
      wait_hi(1, 3000);
      $display("test monitor_expiry done");
      // Special mode: bypass, rate off, reset disable, forced failure
      do_reset(1'b1, 1'b1);
      cmp8(IDX_WDOG_CTRL, 8'h8F);
      bus(1'b1, IDX_TICK_CTRL, 8'h89);
      cmp8(IDX_TICK_CTRL, 8'h89);
      wait_hi(0, 60);
      @(posedge clk_sys_i);
      wait_mode_i <= 1'b1;
      cmp8(IDX_TICK_CTRL, 8'h89);
      bus(1'b1, IDX_TICK_CTRL, 8'hC9);
      bus(1'b1, IDX_TICK_FLAG, 8'h80);
      hold_lo(0, 100, 1'b0);
      @(posedge clk_sys_i);
      wait_mode_i <= 1'b0;
      wait_hi(0, 60);
      bus(1'b1, IDX_TICK_CTRL, 8'h88);
      bus(1'b1, IDX_TICK_FLAG, 8'h80);
      hold_lo(0, 200, 1'b0);
      bus(1'b1, IDX_WDOG_CTRL, 8'hA9);
      hold_lo(1, 50, 1'b0);
      hold_lo(2, 1, 1'b0);
      bus(1'b1, IDX_WDOG_CTRL, 8'hA1);
      wait_hi(1, 30);
      wait_hi(2, 30);
      $display("test special_force done");
      // Special mode: window servicing
      do_reset(1'b1, 1'b0);
      bus(1'b1, IDX_WDOG_CTRL, 8'h12);
      hold_lo(1, 26500, 1'b0);
      bus(1'b1, IDX_WDOG_SERV, SERV_ARM);
      bus(1'b1, IDX_WDOG_SERV, SERV_ARM);
      bus(1'b1, IDX_WDOG_SERV, SERV_RESTART);
      hold_lo(1, 100, 1'b0);
      bus(1'b1, IDX_WDOG_SERV, SERV_ARM);
      wait_hi(1, 20);
      do_reset(1'b1, 1'b0);
      bus(1'b1, IDX_WDOG_CTRL, 8'h01);
      bus(1'b1, IDX_WDOG_SERV, 8'h12);
      wait_hi(1, 20);
      $display("test window_bad_value done");
      conclude();
   end
endmodule
